/* File: hdl/reset_ctl_pkg.sv */
// Constants, register map and types of the system reset source controller.
// Assumes a single 50 MHz core clock and an 8-bit register port.
package reset_ctl_pkg;

  // Core clock and timing
  localparam int CLK_PERIOD_NS    = 20;
  localparam int POR_DELAY_NS     = 300000;
  localparam int POR_DELAY_CYCLES = POR_DELAY_NS / CLK_PERIOD_NS;
  localparam int WDT_CLK_DIV      = 12;
  localparam logic [3:0] WDT_DIV_LAST = 4'(WDT_CLK_DIV - 1);
  localparam logic [2:0] MIN_HOLD_CYCLES  = 3'h4;
  localparam logic [2:0] PIN_GUARD_CYCLES = 3'h4;

  // Register offsets
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'hEF;
  localparam logic [7:0] ADDR_SUPPLY_CTL  = 8'hFF;
  localparam logic [7:0] ADDR_WDT_CTL     = 8'hD9;
  localparam logic [7:0] ADDR_WDT_PERIOD  = 8'hDA;

  // Field positions
  localparam int PIN_FLAG_BIT   = 0;
  localparam int POR_FLAG_BIT   = 1;
  localparam int CLK_FLAG_BIT   = 2;
  localparam int WDT_FLAG_BIT   = 3;
  localparam int SW_FLAG_BIT    = 4;
  localparam int CMP_FLAG_BIT   = 5;
  localparam int SUP_EN_BIT     = 7;
  localparam int SUP_STAT_BIT   = 6;
  localparam int WDT_EN_BIT     = 0;
  localparam int WDT_SERVE_BIT  = 1;

  // Values after reset
  localparam logic [7:0]  WDT_PERIOD_RESET = 8'hFF;
  localparam logic [7:0]  PORT_LATCH_RESET = 8'hFF;
  localparam logic [15:0] BOOT_ADDR        = 16'h0000;
  localparam logic [3:0]  SYNC_INIT        = 4'h6;

  typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_RUN} state_t;

  typedef enum logic [2:0] {C_POR, C_SUPPLY, C_PIN, C_CLK, C_CMP, C_WDT, C_SW} cause_t;

  typedef struct packed {
    logic sup_sel;
    logic clk_loss_en;
    logic cmp_sel;
    logic wdt_en;
  } src_sel_t;

  localparam src_sel_t SEL_POR = '{sup_sel: 1'b1, clk_loss_en: 1'b0, cmp_sel: 1'b0, wdt_en: 1'b1};

endpackage

/* File: hdl/sync_bank.sv */
// Two-stage synchroniser for a group of independent asynchronous levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ps
`default_nettype none
module sync_bank #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

/* File: hdl/reset_source_ctl.sv */
// System reset source controller: merges reset requests, records the cause.
// Assumes rst is the power-on reset, pins are asynchronous, core_clk 50 MHz.
//
// Function
// - Reset state halts core, loads defaults
// - Data memory kept except after power-on
// - Port latches all ones, open-drain, pull-ups
// - Power and supply resets drive pin low
// - Exit clears PC, internal clock, fetch zero
// - Watchdog enabled after any reset, clock/12
// - Power-on delay before release
// - Power-on flag set, cleared by others
// - Supply monitor enabled by power-on or register write
// - Writing pin flag forces power-on reset
// - Supply low holds reset until recovered
// - Low pin resets; pin flag set after
// - Missing clock resets; flag shows it
// - Clock-loss flag write enables detector
// - Comparator low resets when selected
// - Watchdog expiry resets, sets its flag
// - Other internal resets leave pin alone
// - Software reset bit forces reset, flags
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module reset_source_ctl #(
  parameter int POR_DELAY_CYCLES = reset_ctl_pkg::POR_DELAY_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [7:0]  reg_rdata,
  input  wire logic        supply_ok_in,
  input  wire logic        comparator_in,
  input  wire logic        reset_n_in,
  input  wire logic        clock_missing_in,
  output logic             sys_reset,
  output logic             reset_n_out,
  output logic             reset_n_oe,
  output logic      [7:0]  port_latch_value,
  output logic             port_open_drain,
  output logic             weak_pullup_en,
  output logic             reset_exit,
  output logic      [15:0] boot_addr,
  output logic             ram_retained
);

  localparam int CW = $clog2(POR_DELAY_CYCLES + 1);
  localparam logic [CW-1:0] DELAY_LAST = CW'(POR_DELAY_CYCLES - 1);

  reset_ctl_pkg::state_t   state_reg;
  reset_ctl_pkg::state_t   state_next;
  reset_ctl_pkg::cause_t   cause_reg;
  reset_ctl_pkg::cause_t   cause_next;
  reset_ctl_pkg::cause_t   req_cause;
  reset_ctl_pkg::src_sel_t sel_reg;
  reset_ctl_pkg::src_sel_t sel_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [2:0]    guard_reg;
  logic [3:0]    div_reg;
  logic [15:0]   wdt_cnt_reg;
  logic [15:0]   wdt_cnt_next;
  logic [7:0]    wdt_period_reg;
  logic          mon_en_reg;
  logic          mon_en_next;
  logic [7:0]    rdata_reg;
  logic          sys_reset_reg;
  logic          pin_oe_reg;
  logic          pin_out_reg;
  logic [7:0]    port_latch_reg;
  logic          open_drain_reg;
  logic          pullup_reg;
  logic          exit_reg;
  logic [15:0]   boot_addr_reg;
  logic          ram_retained_reg;
  logic [3:0]    raw_in;
  logic [3:0]    sync_bits;

  // Asynchronous levels into the core domain
  assign raw_in = {clock_missing_in, comparator_in, reset_n_in, supply_ok_in};

  sync_bank #(
    .WIDTH (4),
    .INIT  (reset_ctl_pkg::SYNC_INIT)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (raw_in),
    .sync_out (sync_bits)
  );

  wire supply_ok_s  = sync_bits[0];
  wire pin_n_s      = sync_bits[1];
  wire cmp_s        = sync_bits[2];
  wire clk_miss_s   = sync_bits[3];

  // Register decode
  wire run       = state_reg == reset_ctl_pkg::ST_RUN;
  wire cause_wr  = run && reg_we && reg_addr == reset_ctl_pkg::ADDR_RESET_CAUSE;
  wire sup_wr    = run && reg_we && reg_addr == reset_ctl_pkg::ADDR_SUPPLY_CTL;
  wire wdt_wr    = run && reg_we && reg_addr == reset_ctl_pkg::ADDR_WDT_CTL;
  wire per_wr    = run && reg_we && reg_addr == reset_ctl_pkg::ADDR_WDT_PERIOD;
  wire wdt_serve = wdt_wr && reg_wdata[reset_ctl_pkg::WDT_SERVE_BIT];

  // Watchdog clock from system clock / 12
  wire wdt_tick   = div_reg == reset_ctl_pkg::WDT_DIV_LAST;
  wire wdt_expire = sel_reg.wdt_en && wdt_tick && wdt_cnt_reg == {wdt_period_reg, 8'hFF};

  assign wdt_cnt_next = (!run || wdt_serve || !sel_reg.wdt_en) ? 16'h0000 :
                        wdt_tick ? wdt_cnt_reg + 16'h0001 : wdt_cnt_reg;

  // Reset requests seen while running
  wire req_por = cause_wr && reg_wdata[reset_ctl_pkg::PIN_FLAG_BIT];
  wire req_sup = run && mon_en_reg && sel_reg.sup_sel && !supply_ok_s;
  wire req_pin = run && guard_reg == 3'h0 && !pin_n_s;
  wire req_clk = run && sel_reg.clk_loss_en && clk_miss_s;
  wire req_cmp = run && sel_reg.cmp_sel && !cmp_s;
  wire req_wdt = run && wdt_expire;
  wire req_sw  = cause_wr && reg_wdata[reset_ctl_pkg::SW_FLAG_BIT];
  wire any_req = req_por || req_sup || req_pin || req_clk || req_cmp || req_wdt || req_sw;
  wire enter   = run && any_req;

  assign req_cause = req_por ? reset_ctl_pkg::C_POR :
                     req_sup ? reset_ctl_pkg::C_SUPPLY :
                     req_pin ? reset_ctl_pkg::C_PIN :
                     req_clk ? reset_ctl_pkg::C_CLK :
                     req_cmp ? reset_ctl_pkg::C_CMP :
                     req_wdt ? reset_ctl_pkg::C_WDT : reset_ctl_pkg::C_SW;

  assign cause_next = enter ? req_cause : cause_reg;

  // Hold while the latched source is still active
  wire power_cause = cause_reg == reset_ctl_pkg::C_POR || cause_reg == reset_ctl_pkg::C_SUPPLY;
  wire hold_cond   = power_cause ? !supply_ok_s :
                     cause_reg == reset_ctl_pkg::C_PIN ? !pin_n_s :
                     cause_reg == reset_ctl_pkg::C_CLK ? clk_miss_s :
                     cause_reg == reset_ctl_pkg::C_CMP ? !cmp_s : 1'b0;
  wire hold_done   = cnt_reg >= CW'(reset_ctl_pkg::MIN_HOLD_CYCLES) && !hold_cond;
  wire delay_done  = cnt_reg == DELAY_LAST;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      reset_ctl_pkg::ST_RUN: begin
        if (any_req) begin
          state_next = reset_ctl_pkg::ST_HOLD;
        end
      end
      reset_ctl_pkg::ST_HOLD: begin
        if (hold_done) begin
          state_next = power_cause ? reset_ctl_pkg::ST_DELAY : reset_ctl_pkg::ST_RUN;
        end
      end
      reset_ctl_pkg::ST_DELAY: begin
        if (hold_cond) begin
          state_next = reset_ctl_pkg::ST_HOLD;
        end else if (delay_done) begin
          state_next = reset_ctl_pkg::ST_RUN;
        end
      end
    endcase
  end

  assign cnt_next = (state_next != state_reg) ? '0 : (&cnt_reg) ? cnt_reg : cnt_reg + CW'(1);

  // Source selects: entry to reset wins over a register write
  always_comb begin
    sel_next = sel_reg;
    if (enter) begin
      sel_next = reset_ctl_pkg::SEL_POR;
      if (req_cause != reset_ctl_pkg::C_POR) begin
        sel_next.sup_sel = sel_reg.sup_sel;
      end
    end else if (cause_wr) begin
      sel_next.sup_sel     = reg_wdata[reset_ctl_pkg::POR_FLAG_BIT];
      sel_next.clk_loss_en = reg_wdata[reset_ctl_pkg::CLK_FLAG_BIT];
      sel_next.cmp_sel     = reg_wdata[reset_ctl_pkg::CMP_FLAG_BIT];
    end else if (wdt_wr) begin
      sel_next.wdt_en = reg_wdata[reset_ctl_pkg::WDT_EN_BIT];
    end
  end

  assign mon_en_next = enter ? ((req_cause == reset_ctl_pkg::C_POR) ? 1'b1 : mon_en_reg) :
                       sup_wr ? reg_wdata[reset_ctl_pkg::SUP_EN_BIT] : mon_en_reg;

  // Read path
  wire [7:0] cause_flags = {2'b00,
                            cause_reg == reset_ctl_pkg::C_CMP,
                            cause_reg == reset_ctl_pkg::C_SW,
                            cause_reg == reset_ctl_pkg::C_WDT,
                            cause_reg == reset_ctl_pkg::C_CLK,
                            cause_reg == reset_ctl_pkg::C_POR,
                            cause_reg == reset_ctl_pkg::C_PIN};
  wire [7:0] sup_rd    = {mon_en_reg, supply_ok_s, 6'b000000};
  wire [7:0] wdt_rd    = {7'b0000000, sel_reg.wdt_en};
  wire [7:0] rd_mux    = reg_addr == reset_ctl_pkg::ADDR_RESET_CAUSE ? cause_flags :
                         reg_addr == reset_ctl_pkg::ADDR_SUPPLY_CTL  ? sup_rd :
                         reg_addr == reset_ctl_pkg::ADDR_WDT_CTL     ? wdt_rd :
                         reg_addr == reset_ctl_pkg::ADDR_WDT_PERIOD  ? wdt_period_reg : 8'h00;

  wire pin_drive = state_next != reset_ctl_pkg::ST_RUN &&
                   (cause_next == reset_ctl_pkg::C_POR || cause_next == reset_ctl_pkg::C_SUPPLY);
  wire leaving   = !run && state_next == reset_ctl_pkg::ST_RUN;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= reset_ctl_pkg::ST_HOLD;
      cause_reg <= reset_ctl_pkg::C_POR;
      cnt_reg   <= '0;
      sel_reg   <= reset_ctl_pkg::SEL_POR;
      mon_en_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      cnt_reg   <= cnt_next;
      sel_reg   <= sel_next;
      mon_en_reg <= mon_en_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_reg        <= 4'h0;
      wdt_cnt_reg    <= 16'h0000;
      wdt_period_reg <= reset_ctl_pkg::WDT_PERIOD_RESET;
      guard_reg      <= 3'h0;
    end else begin
      div_reg        <= wdt_tick ? 4'h0 : div_reg + 4'h1;
      wdt_cnt_reg    <= wdt_cnt_next;
      wdt_period_reg <= enter ? reset_ctl_pkg::WDT_PERIOD_RESET : per_wr ? reg_wdata : wdt_period_reg;
      // Pin still reads low for a few cycles after the drive is released
      guard_reg      <= leaving ? reset_ctl_pkg::PIN_GUARD_CYCLES :
                        (guard_reg != 3'h0) ? guard_reg - 3'h1 : guard_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg        <= 8'h00;
      sys_reset_reg    <= 1'b1;
      pin_oe_reg       <= 1'b1;
      pin_out_reg      <= 1'b0;
      port_latch_reg   <= reset_ctl_pkg::PORT_LATCH_RESET;
      open_drain_reg   <= 1'b1;
      pullup_reg       <= 1'b1;
      exit_reg         <= 1'b0;
      boot_addr_reg    <= reset_ctl_pkg::BOOT_ADDR;
      ram_retained_reg <= 1'b0;
    end else begin
      rdata_reg        <= reg_re ? rd_mux : 8'h00;
      sys_reset_reg    <= state_next != reset_ctl_pkg::ST_RUN;
      pin_oe_reg       <= pin_drive;
      pin_out_reg      <= 1'b0;
      port_latch_reg   <= (state_next != reset_ctl_pkg::ST_RUN) ? reset_ctl_pkg::PORT_LATCH_RESET : port_latch_reg;
      open_drain_reg   <= (state_next != reset_ctl_pkg::ST_RUN) ? 1'b1 : open_drain_reg;
      pullup_reg       <= 1'b1;
      exit_reg         <= leaving;
      boot_addr_reg    <= reset_ctl_pkg::BOOT_ADDR;
      ram_retained_reg <= enter ? (req_cause != reset_ctl_pkg::C_POR) : ram_retained_reg;
    end
  end

  assign reg_rdata        = rdata_reg;
  assign sys_reset        = sys_reset_reg;
  assign reset_n_out      = pin_out_reg;
  assign reset_n_oe       = pin_oe_reg;
  assign port_latch_value = port_latch_reg;
  assign port_open_drain  = open_drain_reg;
  assign weak_pullup_en   = pullup_reg;
  assign reset_exit       = exit_reg;
  assign boot_addr        = boot_addr_reg;
  assign ram_retained     = ram_retained_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_wdt_cause: assert property (req_wdt && !req_por && !req_sup && !req_pin && !req_clk && !req_cmp
    |=> sys_reset_reg && cause_reg == reset_ctl_pkg::C_WDT && !pin_oe_reg)
    else $error("watchdog expiry did not reset");

  chk_sw_reset: assert property (req_sw |=> sys_reset_reg ##0 !exit_reg)
    else $error("software reset not taken");

  chk_pin_quiet: assert property (sys_reset_reg && !power_cause |-> !pin_oe_reg)
    else $error("reset pin driven by internal reset");

  chk_pin_power: assert property (sys_reset_reg && power_cause && $past(sys_reset_reg) |-> pin_oe_reg)
    else $error("reset pin not driven for power reset");

  chk_por_delay: assert property ($fell(sys_reset_reg) && power_cause
    |-> $past(state_reg) == reset_ctl_pkg::ST_DELAY && $past(cnt_reg) == DELAY_LAST)
    else $error("power-on delay skipped");

  chk_mon_keep: assert property (enter && req_cause != reset_ctl_pkg::C_POR
    |=> mon_en_reg == $past(mon_en_reg))
    else $error("supply monitor enable changed by reset");

  chk_wdt_on: assert property ($fell(sys_reset_reg) |-> sel_reg.wdt_en && wdt_cnt_reg == 16'h0000)
    else $error("watchdog off after reset");

  chk_cmp_hold: assert property (sys_reset_reg && cause_reg == reset_ctl_pkg::C_CMP && !cmp_s
    |=> sys_reset_reg && state_reg == reset_ctl_pkg::ST_HOLD)
    else $error("comparator reset released early");

  chk_por_flag: assert property (reg_re && reg_addr == reset_ctl_pkg::ADDR_RESET_CAUSE
    |=> rdata_reg[reset_ctl_pkg::POR_FLAG_BIT] == ($past(cause_reg) == reset_ctl_pkg::C_POR))
    else $error("power-on flag wrong");

  chk_exit_boot: assert property ($fell(sys_reset_reg) |-> exit_reg ##1 !exit_reg)
    else $error("exit pulse missing");

  chk_supply_stat: assert property (reg_re && reg_addr == reset_ctl_pkg::ADDR_SUPPLY_CTL
    |=> rdata_reg[reset_ctl_pkg::SUP_STAT_BIT] == $past(supply_ok_s))
    else $error("supply status wrong");

  chk_port_state: assert property (sys_reset_reg
    |-> port_latch_reg == reset_ctl_pkg::PORT_LATCH_RESET && open_drain_reg && pullup_reg)
    else $error("port state wrong in reset");

  chk_ram_power: assert property (enter
    |=> ram_retained_reg == ($past(req_cause) != reset_ctl_pkg::C_POR))
    else $error("memory retention flag wrong");

  chk_mon_por: assert property (enter && req_cause == reset_ctl_pkg::C_POR
    |=> mon_en_reg)
    else $error("supply monitor not enabled by power-on");

  chk_pin_cause: assert property (req_pin && !req_por && !req_sup
    |=> sys_reset_reg && cause_reg == reset_ctl_pkg::C_PIN && !pin_oe_reg)
    else $error("pin reset not taken");

  chk_sup_hold: assert property (sys_reset_reg && power_cause && !supply_ok_s
    |=> sys_reset_reg && state_reg == reset_ctl_pkg::ST_HOLD)
    else $error("reset released with supply low");

endmodule
`default_nettype wire

/* File: verif/reset_pin_partner.sv */
// Far side of the reset controller: supply monitor, comparator, reset pin, clock-missing pass-through.
// Assumes the bench sets the condition levels; the pin has an external pull-up.
`timescale 1ns/1ps
`default_nettype none
module reset_pin_partner (
  input  wire logic pull_low,
  input  wire logic supply_low,
  input  wire logic cmp_low,
  input  wire logic clk_missing,
  input  wire logic reset_n_out,
  input  wire logic reset_n_oe,
  output logic      supply_ok_in,
  output logic      comparator_in,
  output logic      reset_n_in,
  output logic      clock_missing_in,
  output logic      pin_level
);
  // Pin resolves device drive, external pull-down and pull-up
  assign pin_level        = reset_n_oe ? reset_n_out : (pull_low ? 1'b0 : 1'b1);
  assign reset_n_in       = pin_level;
  assign supply_ok_in     = ~supply_low;
  assign comparator_in    = ~cmp_low;
  assign clock_missing_in = clk_missing;
endmodule
`default_nettype wire

/* File: verif/system_reset_source_controller_bench.sv */
// Self-checking bench for the reset source controller.
// Assumes the partner model drives all analog and pin inputs.
`timescale 1ns/1ps
`default_nettype none
module system_reset_source_controller_bench;
  localparam int POR_SIM = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic pull_low = 1'b0, supply_low = 1'b1, cmp_low = 1'b0, clk_missing = 1'b0;
  logic supply_ok_in, comparator_in, reset_n_in, clock_missing_in, pin_level;
  logic sys_reset, reset_n_out, reset_n_oe, port_open_drain, weak_pullup_en, reset_exit, ram_retained;
  logic [7:0] port_latch_value;
  logic [15:0] boot_addr;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] rv;

  always #10 core_clk = ~core_clk;

  reset_source_ctl #(.POR_DELAY_CYCLES(POR_SIM)) dut_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .supply_ok_in(supply_ok_in), .comparator_in(comparator_in),
    .reset_n_in(reset_n_in), .clock_missing_in(clock_missing_in), .sys_reset(sys_reset),
    .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe), .port_latch_value(port_latch_value),
    .port_open_drain(port_open_drain), .weak_pullup_en(weak_pullup_en), .reset_exit(reset_exit),
    .boot_addr(boot_addr), .ram_retained(ram_retained));

  reset_pin_partner far_u (
    .pull_low(pull_low), .supply_low(supply_low), .cmp_low(cmp_low), .clk_missing(clk_missing),
    .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe), .supply_ok_in(supply_ok_in),
    .comparator_in(comparator_in), .reset_n_in(reset_n_in), .clock_missing_in(clock_missing_in),
    .pin_level(pin_level));

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Waits for entry, holds the source, releases it and follows the exit
  task automatic expect_reset(input logic oe, input logic [7:0] flag, input int hold, input int min_rel,
                              input int rise_bound, output int rise);
    int bad;
    int rel;
    bad = 0;
    rise = 0;
    rel = 0;
    while (sys_reset !== 1'b1) begin
      @(posedge core_clk);
      #1;
      rise++;
      if (rise > rise_bound) begin
        miscompares++;
        end_sim();
      end
    end
    repeat (hold) begin
      @(posedge core_clk);
      #1;
      if (sys_reset !== 1'b1 || reset_n_oe !== oe || (oe && pin_level !== 1'b0)) bad++;
    end
    @(posedge core_clk);
    pull_low <= 1'b0;
    supply_low <= 1'b0;
    cmp_low <= 1'b0;
    clk_missing <= 1'b0;
    #1;
    while (sys_reset !== 1'b0) begin
      if (reset_n_oe !== oe) bad++;
      @(posedge core_clk);
      #1;
      rel++;
      if (rel > 2000) begin
        miscompares++;
        end_sim();
      end
    end
    check(16'(bad), 16'h0000);
    check(16'(rel >= min_rel), 16'h0001);
    check({15'h0, reset_exit}, 16'h0001);
    check(boot_addr, 16'h0000);
    check({8'h00, port_latch_value}, 16'h00FF);
    check({14'h0, port_open_drain, weak_pullup_en}, 16'h0003);
    rd(8'hEF, rv);
    check({8'h00, rv}, {8'h00, flag});
  endtask

  task automatic por_test();
    int r;
    rst <= 1'b0;
    idle(30);
    check({15'h0, sys_reset}, 16'h0001);
    expect_reset(1'b1, 8'h02, 0, POR_SIM, 5, r);
    check({15'h0, ram_retained}, 16'h0000);
    rd(8'hFF, rv);
    check({8'h00, rv}, 16'h00C0);
    rd(8'hDA, rv);
    check({8'h00, rv}, 16'h00FF);
    rd(8'hD9, rv);
    check({8'h00, rv & 8'h01}, 16'h0001);
    rd(8'h00, rv);
    check({8'h00, rv}, 16'h0000);
  endtask

  task automatic sw_test();
    int r;
    wr(8'hEF, 8'h10);
    expect_reset(1'b0, 8'h10, 0, 0, 10, r);
    check({15'h0, ram_retained}, 16'h0001);
    rd(8'hFF, rv);
    check({8'h00, rv}, 16'h00C0);
  endtask

  task automatic pin_test();
    int r;
    @(posedge core_clk);
    pull_low <= 1'b1;
    expect_reset(1'b0, 8'h01, 10, 0, 20, r);
  endtask

  task automatic supply_test();
    int r;
    @(posedge core_clk);
    supply_low <= 1'b1;
    expect_reset(1'b1, 8'h00, 10, POR_SIM, 20, r);
  endtask

  task automatic monitor_keep_test();
    int r;
    wr(8'hFF, 8'h00);
    wr(8'hEF, 8'h10);
    expect_reset(1'b0, 8'h10, 0, 0, 10, r);
    rd(8'hFF, rv);
    check({8'h00, rv}, 16'h0040);
    wr(8'hEF, 8'h01);                        // Monitor back on
    expect_reset(1'b1, 8'h02, 0, POR_SIM, 10, r);
    rd(8'hFF, rv);
    check({8'h00, rv}, 16'h00C0);
    check({15'h0, ram_retained}, 16'h0000);
  endtask

  task automatic clk_test();
    int r;
    wr(8'hEF, 8'h02);
    @(posedge core_clk);
    clk_missing <= 1'b1;
    idle(10);
    clk_missing <= 1'b0;
    idle(5);
    check({15'h0, sys_reset}, 16'h0000);
    wr(8'hEF, 8'h06);
    @(posedge core_clk);
    clk_missing <= 1'b1;
    expect_reset(1'b0, 8'h04, 5, 0, 20, r);
  endtask

  task automatic cmp_test();
    int r;
    @(posedge core_clk);
    cmp_low <= 1'b1;
    idle(10);
    check({15'h0, sys_reset}, 16'h0000);
    cmp_low <= 1'b0;
    idle(5);
    wr(8'hEF, 8'h22);
    @(posedge core_clk);
    cmp_low <= 1'b1;
    expect_reset(1'b0, 8'h20, 10, 0, 20, r);
  endtask

  task automatic wdt_test();
    int r;
    wr(8'hDA, 8'h00);
    idle(2000);
    check({15'h0, sys_reset}, 16'h0000);
    wr(8'hD9, 8'h03);
    expect_reset(1'b0, 8'h08, 0, 0, 5000, r);
    check(16'(r >= 2500), 16'h0001);
    rd(8'hDA, rv);
    check({8'h00, rv}, 16'h00FF);
  endtask

  // Power-on reset in mid-run, after the monitor was switched off
  task automatic mid_rst_test();
    int r;
    wr(8'hFF, 8'h00);
    rst <= 1'b1;
    idle(3);
    check({14'h0, sys_reset, reset_n_oe}, 16'h0003);
    rst <= 1'b0;
    expect_reset(1'b1, 8'h02, 0, POR_SIM, 5, r);
    rd(8'hFF, rv);
    check({8'h00, rv}, 16'h00C0);
    check({15'h0, ram_retained}, 16'h0000);
  endtask

  initial begin
    idle(20);
    por_test();
    sw_test();
    pin_test();
    supply_test();
    monitor_keep_test();
    clk_test();
    cmp_test();
    wdt_test();
    mid_rst_test();
    end_sim();
  end
endmodule
`default_nettype wire
